// ==== core/iqpo_pkg.sv ====
/*
 * package of the interpolated quadrature pulse output: factor codes, struct types.
 * assumes a single clock domain; no software-visible registers.
 */
package iqpo_pkg;
	// phase accumulator width: one metered volume period is 2**PHASE_W steps
	localparam int PHASE_W = 24;
	localparam int SENSE_W = 12;
	localparam logic [PHASE_W-1:0] PHASE_RST = 24'h000000;
	localparam logic [5:0] FACTOR_RST = 6'h01;
	// interpolation subdivisions per period in quarter steps (4 x factor)
	localparam logic [7:0] EDGES_PER_FACTOR = 8'h04;
	localparam logic [5:0] ZERO_PULSE_CYCLES = 6'h04;
	localparam logic [1:0] QUAD_RST = 2'h0;

	typedef struct packed {
		logic chan_a;
		logic chan_b;
		logic zero;
	} iqpo_pulses_t;

	typedef struct packed {
		logic valid;
		logic signed [SENSE_W-1:0] delta;
	} iqpo_motion_t;

	typedef enum logic [1:0] {
		IQPO_IDLE,
		IQPO_ZERO
	} iqpo_zero_state_t;
endpackage

// ==== core/iqpo_output.sv ====
/*
 * interpolated quadrature pulse output: turns sensed rotor phase steps into two
 * quadrature channels and a zero pulse per metered volume period.
 * assumes motion_in comes from sensing logic on clk_sys_in and that the
 * interpolation factor strap is stable; it is caught once at reset release.
 */
`timescale 1ns/1ps
// What the document requires of this block and its evaluation
// RULE_01: drive two quadrature channels whose rate follows the interpolation factor
// RULE_02: evaluation logic finds direction from the quarter-period phase offset
// RULE_03: interpolation factor fixed at manufacture to one of eleven allowed values
// RULE_04: each channel gives factor full pulses per metered volume period
// RULE_05: both edges of both channels give four times factor per period
// RULE_06: one zero pulse per completed metered volume period
// RULE_07: pulse frequency equals flow times factor over volume per period
// RULE_08: evaluation weights edges by half or quarter of volume per pulse; iqpo_eval counts each edge as one
// RULE_09: evaluation scales pulses by volume per pulse or its K-factor; iqpo_eval keeps raw unscaled counts
// RULE_10: angular resolution per edge is quarter period over factor
// RULE_11: evaluation samples synchronously, counts up/down, flags double changes
module iqpo_output #(
	parameter int PHASE_W = iqpo_pkg::PHASE_W,
	parameter int SENSE_W = iqpo_pkg::SENSE_W
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [5:0] interpolation_factor_in,
	input wire iqpo_pkg::iqpo_motion_t motion_in,
	output iqpo_pkg::iqpo_pulses_t pulses_out,
	output logic factor_invalid_out
);
	// ****************************************
	// factor strap
	// ****************************************
	logic [5:0] strap_s1_r;
	logic [5:0] strap_s2_r;
	logic [5:0] interpolation_factor_r;
	logic factor_loaded_r;
	logic factor_ok;

	// RULE_03: allowed factor set
	assign factor_ok = (strap_s2_r == 6'h01) || (strap_s2_r == 6'h02) ||
		(strap_s2_r == 6'h03) || (strap_s2_r == 6'h04) || (strap_s2_r == 6'h05) ||
		(strap_s2_r == 6'h08) || (strap_s2_r == 6'h0A) || (strap_s2_r == 6'h0C) ||
		(strap_s2_r == 6'h10) || (strap_s2_r == 6'h18) || (strap_s2_r == 6'h20);

	always_ff @(posedge clk_sys_in) begin
		strap_s1_r <= interpolation_factor_in;
		strap_s2_r <= strap_s1_r;
	end

	// RULE_03: latch once after reset
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			interpolation_factor_r <= iqpo_pkg::FACTOR_RST;
			factor_loaded_r <= 1'b0;
			factor_invalid_out <= 1'b0;
		end else if (!factor_loaded_r) begin
			factor_loaded_r <= 1'b1;
			interpolation_factor_r <= factor_ok ? strap_s2_r : iqpo_pkg::FACTOR_RST;
			factor_invalid_out <= !factor_ok;
		end
	end

	// ****************************************
	// rotor phase
	// ****************************************
	logic [PHASE_W-1:0] phase_r;
	logic [PHASE_W-1:0] phase_nxt;
	logic [PHASE_W-1:0] step_ext;
	logic [PHASE_W-1:0] step_sel;
	logic step_neg;
	logic wrap_fwd;
	logic wrap_rev;

	// sign-extend the sensed step; an idle cycle adds nothing
	assign step_ext = PHASE_W'(signed'(motion_in.delta));
	assign step_sel = motion_in.valid ? step_ext : '0;
	assign step_neg = motion_in.delta[SENSE_W-1];
	// phase arithmetic is modulo one metered volume period
	assign phase_nxt = PHASE_W'(phase_r + step_sel);
	// RULE_06: period completes when the phase wraps
	// a carry going forward or a borrow going back closes a period
	assign wrap_fwd = motion_in.valid && !step_neg && (phase_nxt < phase_r);
	assign wrap_rev = motion_in.valid && step_neg && (phase_nxt > phase_r);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			phase_r <= iqpo_pkg::PHASE_RST;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ****************************************
	// interpolation
	// ****************************************
	logic [PHASE_W+7:0] scaled;
	logic [7:0] edge_tgt;
	logic [7:0] edge_pos_r;
	logic [7:0] edge_pos_nxt;
	logic [7:0] edge_inc;
	logic [7:0] edge_dec;
	logic [7:0] edge_max;
	logic [7:0] edge_last;
	logic [7:0] edge_half;
	logic [7:0] edge_gap;
	logic step_up;
	logic step_dn;
	logic [1:0] quad_r;
	logic [1:0] quad_nxt;
	logic track_hold;

	// RULE_05: 4 x factor quarter steps per period
	assign edge_max = 8'(iqpo_pkg::EDGES_PER_FACTOR * interpolation_factor_r);
	assign edge_last = 8'(edge_max - 8'h01);
	assign edge_half = edge_max >> 1;
	// RULE_07: edge rate tracks phase rate times factor
	// RULE_10: each quarter step spans a quarter period over factor
	assign scaled = (PHASE_W+8)'(phase_r) * (PHASE_W+8)'(edge_max);
	assign edge_tgt = scaled[PHASE_W+7:PHASE_W];

	// distance ahead is taken modulo the edges of one period, so a period
	// boundary is crossed the short way round, not unwound through every edge
	assign edge_gap = (edge_tgt >= edge_pos_r) ? 8'(edge_tgt - edge_pos_r) :
		8'(edge_tgt + edge_max - edge_pos_r);
	assign step_up = (edge_gap != 8'h00) && (edge_gap < edge_half);
	assign step_dn = (edge_gap != 8'h00) && !step_up;

	// one quarter step per clock keeps single-channel changes only
	assign edge_inc = (edge_pos_r == edge_last) ? 8'h00 : 8'(edge_pos_r + 8'h01);
	assign edge_dec = (edge_pos_r == 8'h00) ? edge_last : 8'(edge_pos_r - 8'h01);
	assign edge_pos_nxt = step_up ? edge_inc : (step_dn ? edge_dec : edge_pos_r);
	assign quad_nxt = step_up ? 2'(quad_r + 2'h1) : (step_dn ? 2'(quad_r - 2'h1) : quad_r);
	// the tracker waits until the factor has been caught
	assign track_hold = rst_in || !factor_loaded_r;

	always_ff @(posedge clk_sys_in) begin
		if (track_hold) begin
			edge_pos_r <= 8'h00;
			quad_r <= iqpo_pkg::QUAD_RST;
		end else begin
			edge_pos_r <= edge_pos_nxt;
			quad_r <= quad_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	iqpo_pkg::iqpo_zero_state_t zstate_r;
	iqpo_pkg::iqpo_zero_state_t zstate_nxt;
	logic [5:0] zcnt_r;
	logic [5:0] zcnt_nxt;
	logic zero_r;
	logic zero_nxt;
	logic chan_a_r;
	logic chan_a_nxt;
	logic chan_b_r;
	logic chan_b_nxt;
	logic zero_hit;

	assign zero_hit = factor_loaded_r && (wrap_fwd || wrap_rev);

	// RULE_06: stretched zero pulse
	// a wrap seen while the pulse stands is dropped, not queued
	always_comb begin
		zstate_nxt = zstate_r;
		zcnt_nxt = zcnt_r;
		zero_nxt = zero_r;
		case (zstate_r)
			iqpo_pkg::IQPO_IDLE: begin
				zero_nxt = zero_hit;
				zcnt_nxt = iqpo_pkg::ZERO_PULSE_CYCLES;
				if (zero_hit) begin
					zstate_nxt = iqpo_pkg::IQPO_ZERO;
				end
			end
			iqpo_pkg::IQPO_ZERO: begin
				zcnt_nxt = 6'(zcnt_r - 6'h01);
				if (zcnt_r == 6'h01) begin
					zero_nxt = 1'b0;
					zstate_nxt = iqpo_pkg::IQPO_IDLE;
				end
			end
			default: begin
				zstate_nxt = iqpo_pkg::IQPO_IDLE;
				zero_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			zstate_r <= iqpo_pkg::IQPO_IDLE;
			zcnt_r <= 6'h00;
			zero_r <= 1'b0;
		end else begin
			zstate_r <= zstate_nxt;
			zcnt_r <= zcnt_nxt;
			zero_r <= zero_nxt;
		end
	end

	// RULE_01: gray sequence, channel b lags a by a quarter
	// RULE_04: factor full cycles per period
	assign chan_a_nxt = quad_r[1] ^ quad_r[0];
	assign chan_b_nxt = quad_r[1];

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			chan_a_r <= 1'b0;
			chan_b_r <= 1'b0;
		end else begin
			chan_a_r <= chan_a_nxt;
			chan_b_r <= chan_b_nxt;
		end
	end

	// registered levels go straight to the pins
	assign pulses_out.chan_a = chan_a_r;
	assign pulses_out.chan_b = chan_b_r;
	assign pulses_out.zero = zero_r;
endmodule

// ==== verification/iqpo_output_asserts.sv ====
/* port checker of the pulse output; sees the top ports only, bound below */
`timescale 1ns/1ps
module iqpo_output_asserts (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [5:0] interpolation_factor_in,
	input wire iqpo_pkg::iqpo_motion_t motion_in,
	input wire iqpo_pkg::iqpo_pulses_t pulses_out,
	input wire logic factor_invalid_out
);
	// ****
	// checks
	// ****
	logic ok;
	logic [5:0] idle_r;
	assign ok = interpolation_factor_in inside {6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08,
		6'h0A, 6'h0C, 6'h10, 6'h18, 6'h20};
	always_ff @(posedge clk_sys_in)
		idle_r <= (rst_in || motion_in.valid) ? 6'h00 : idle_r + {5'h00, idle_r != 6'h3F};
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_one_step: assert property (!($changed(pulses_out.chan_a) && $changed(pulses_out.chan_b)))
		else $error("both channels moved");
	a_zero_width: assert property ($rose(pulses_out.zero) |-> pulses_out.zero[*4] ##1 !pulses_out.zero)
		else $error("zero pulse width");
	a_zero_cause: assert property ($rose(pulses_out.zero) |-> $past(motion_in.valid) ||
		$past(motion_in.valid, 2) || $past(motion_in.valid, 3))
		else $error("zero pulse without motion");
	a_factor_flag: assert property ($fell(rst_in) |-> ##3 factor_invalid_out == !ok)
		else $error("factor flag wrong");
	a_flag_steady: assert property (!$past(rst_in, 4) |-> $stable(factor_invalid_out))
		else $error("factor flag moved");
	a_hold_still: assert property (idle_r > 6'h10 |-> !$changed(pulses_out))
		else $error("channels moved at rest");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_in |=> pulses_out == 3'h0 && !factor_invalid_out)
		else $error("outputs not quiet in reset");
endmodule
bind iqpo_output iqpo_output_asserts iqpo_output_asserts_i (.clk_sys_in, .rst_in,
	.interpolation_factor_in, .motion_in, .pulses_out, .factor_invalid_out);

// ==== verification/iqpo_eval.sv ====
/* evaluation model: counts edges up or down and zero pulses; shares the output clock */
`timescale 1ns/1ps
module iqpo_eval (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire iqpo_pkg::iqpo_pulses_t pulses_in,
	output logic signed [15:0] edge_count_out,
	output logic [7:0] zero_count_out,
	output logic double_change_out
);
	// ****
	// counting
	// ****
	iqpo_pkg::iqpo_pulses_t prev_r;
	logic step;
	logic fwd;
	logic dbl;
	assign step = pulses_in.chan_a ^ prev_r.chan_a ^ pulses_in.chan_b ^ prev_r.chan_b;
	assign fwd = pulses_in.chan_a ^ prev_r.chan_b;
	assign dbl = pulses_in.chan_a != prev_r.chan_a && pulses_in.chan_b != prev_r.chan_b;
	always_ff @(posedge clk_sys_in) begin
		prev_r <= pulses_in;
		if (rst_in) begin
			edge_count_out <= 16'h0000;
			zero_count_out <= 8'h00;
			double_change_out <= 1'b0;
		end else begin
			edge_count_out <= edge_count_out + (step ? (fwd ? 16'h0001 : 16'hFFFF) : 16'h0000);
			zero_count_out <= zero_count_out + {7'h00, pulses_in.zero & ~prev_r.zero};
			double_change_out <= double_change_out | dbl;
		end
	end
endmodule

// ==== verification/iqpo_output_tb_top.sv ====
/* testbench of the pulse output; drives one period per case, judges the counts */
`timescale 1ns/1ps
module iqpo_output_tb_top;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [5:0] factor = 6'h01;
	iqpo_pkg::iqpo_motion_t motion = '0;
	iqpo_pkg::iqpo_pulses_t pulses;
	logic bad;
	logic signed [15:0] edges;
	logic [7:0] zeros;
	logic dbl;
	int num_errors = 0;
	int cmp_count = 0;
	always #2 clk_sys_in = ~clk_sys_in;
	iqpo_output iqpo_output_i (.clk_sys_in, .rst_in, .interpolation_factor_in(factor),
		.motion_in(motion), .pulses_out(pulses), .factor_invalid_out(bad));
	iqpo_eval iqpo_eval_i (.clk_sys_in, .rst_in, .pulses_in(pulses), .edge_count_out(edges),
		.zero_count_out(zeros), .double_change_out(dbl));
	// ****
	// tasks
	// ****
	task check(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wrap_up();
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task spin(input logic [5:0] f, input logic [11:0] d, input int n);
		factor = f;
		rst_in = 1'b1;
		repeat (5) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		#1 motion = {1'b1, d};
		repeat (n) @(posedge clk_sys_in);
		#1 motion = '0;
		repeat (40) @(posedge clk_sys_in);
		#1;
	endtask
	task judge(input logic [15:0] e, input logic [7:0] z, input logic b);
		check("edges", e, edges);
		check("zeros", {8'h00, z}, {8'h00, zeros});
		check("invalid", {15'h0000, b}, {15'h0000, bad});
		check("double", 16'h0000, {15'h0000, dbl});
	endtask
	task s_forward();
		spin(6'h04, 12'h400, 16384);
		judge(16'h0010, 8'h01, 1'b0);
	endtask
	task s_fine_reverse();
		spin(6'h20, 12'h800, 8192);
		judge(16'hFF80, 8'h01, 1'b0);
	endtask
	task s_bad_strap();
		spin(6'h07, 12'h800, 8192);
		judge(16'hFFFC, 8'h01, 1'b1);
	endtask
	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		s_forward();
		s_fine_reverse();
		s_bad_strap();
		wrap_up();
	end
endmodule
